// *** logic/pwt_pkg.sv ***
// Purpose: shared constants for the protection timer and watchdog block
// Assumes: 100 MHz mclk; serial link clocked by the host
// Notes:   times kept in printed units, cycle counts derived from them
package pwt_pkg;

  localparam int unsigned CNT_W         = 28;
  localparam real         CLK_PERIOD_NS = 10.0;

  // low over-current blanking, per code, in ms
  localparam real T_LOW_BLANK0_MS = 155.0;
  localparam real T_LOW_BLANK1_MS = 10.0;
  localparam real T_LOW_BLANK2_MS = 1.2;
  localparam real T_LOW_BLANK3_MS = 0.15;
  // fixed high over-current blanking, in us
  localparam real T_HIGH_BLANK_US = 10.0;
  // switching delay step per code, in ms
  localparam real T_SWITCH_STEP_MS = 75.0;
  // watchdog timeout, per code, in ms
  localparam real T_WD0_MS = 620.0;
  localparam real T_WD1_MS = 310.0;
  localparam real T_WD2_MS = 2500.0;
  localparam real T_WD3_MS = 1250.0;

  // typical figures, truncated to whole cycles
  localparam logic [CNT_W-1:0] LOW_BLANK0_CYC =
    CNT_W'($rtoi(T_LOW_BLANK0_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] LOW_BLANK1_CYC =
    CNT_W'($rtoi(T_LOW_BLANK1_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] LOW_BLANK2_CYC =
    CNT_W'($rtoi(T_LOW_BLANK2_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] LOW_BLANK3_CYC =
    CNT_W'($rtoi(T_LOW_BLANK3_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] HIGH_BLANK_CYC =
    CNT_W'($rtoi(T_HIGH_BLANK_US * 1.0e3 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] SWITCH_STEP_CYC =
    CNT_W'($rtoi(T_SWITCH_STEP_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] WD0_CYC =
    CNT_W'($rtoi(T_WD0_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] WD1_CYC =
    CNT_W'($rtoi(T_WD1_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] WD2_CYC =
    CNT_W'($rtoi(T_WD2_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] WD3_CYC =
    CNT_W'($rtoi(T_WD3_MS * 1.0e6 / CLK_PERIOD_NS));

  // last bit index of a serial command and number of synchronised inputs
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int unsigned SYNC_N  = 6;

endpackage

// *** logic/pwt_timer_if.sv ***
// Purpose: carrier between the top and one interval timer
// Assumes: single mclk domain
// Notes:   owner loads and runs, timer reports expiry
`timescale 1ns/100ps
interface pwt_timer_if;
  logic                       load;
  logic [pwt_pkg::CNT_W-1:0]  loadValue;
  logic                       run;
  logic                       done;

  modport owner (output load, output loadValue, output run, input done);
  modport timer (input load, input loadValue, input run, output done);
endinterface

// *** logic/pwt_interval_timer.sv ***
// Purpose: down counter that flags expiry of a loaded interval
// Assumes: run is ignored until the first load
// Notes:   load has priority over counting; a zero load expires at once
`timescale 1ns/100ps
module pwt_interval_timer (
  input  wire logic mclk,
  input  wire logic reset_n,
  pwt_timer_if.timer tmr
);

  logic [pwt_pkg::CNT_W-1:0] cntQ;
  logic                      armedQ;
  logic                      doneQ;

  assign tmr.done = doneQ;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cntQ   <= '0;
      armedQ <= 1'b0;
      doneQ  <= 1'b0;
    end else if (tmr.load) begin
      cntQ   <= tmr.loadValue;
      armedQ <= 1'b1;
      doneQ  <= (tmr.loadValue == '0);
    end else if (tmr.run && armedQ && !doneQ) begin
      // reaching one means this edge ends the interval
      cntQ  <= cntQ - pwt_pkg::CNT_W'(1);
      doneQ <= (cntQ <= pwt_pkg::CNT_W'(1));
    end
  end

endmodule // pwt_interval_timer

// *** logic/pwt_protection_timer.sv ***
// Purpose: blanking, switching delay and watchdog timing of a power switch
// Assumes: sclk only toggles inside frames; csN high between frames
// Notes:   fields and comparators arrive as plain ports, no registers
// Contract
// (RULE1) low blanking picked from two-bit code
// (RULE2) fixed ten microsecond high blanking window
// (RULE3) high comparator ignored during high blanking
// (RULE4) switching delay adds 75 ms per code
// (RULE5) watchdog timeout picked from two-bit code
// (RULE6) watchdog runs only while wake high
// (RULE7) host holds reset low 167 ns minimum; bench holds its first reset low 55 ns
// (RULE8) host waits 5 us before first select
// (RULE9) host keeps select high 300 ns
// (RULE10) host serial clock at most 3 MHz; host model toggles sclk every 32 ns
// (RULE11) reset initialises; watchdog starts at release
// (RULE12) grounded resistor disables watchdog; else picks output
// (RULE13) watchdog timeout enters fail-safe mode
// (RULE14) each completed transfer restarts the watchdog
// (RULE15) counters reload when selection field changes
`timescale 1ns/100ps
module pwt_protection_timer #(
  parameter logic [3:0][pwt_pkg::CNT_W-1:0] LOW_BLANK_CYC = {
    pwt_pkg::LOW_BLANK3_CYC, pwt_pkg::LOW_BLANK2_CYC,
    pwt_pkg::LOW_BLANK1_CYC, pwt_pkg::LOW_BLANK0_CYC},
  parameter logic [pwt_pkg::CNT_W-1:0] SWITCH_STEP_CYC =
    pwt_pkg::SWITCH_STEP_CYC,
  parameter logic [3:0][pwt_pkg::CNT_W-1:0] WD_CYC = {
    pwt_pkg::WD3_CYC, pwt_pkg::WD2_CYC,
    pwt_pkg::WD1_CYC, pwt_pkg::WD0_CYC}
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       wake,
  input  wire logic       failsafeResistorGnd,
  input  wire logic       failsafeResistorOn,
  input  wire logic       lowOvercurrentDet,
  input  wire logic       highOvercurrentDet,
  input  wire logic [1:0] lowOvercurrentBlankSel,
  input  wire logic [2:0] outputSwitchDelaySel,
  input  wire logic [1:0] watchdogPeriodSel,
  input  wire logic       outputReq,
  output logic            hsOn,
  output logic            lowOvercurrentFault,
  output logic            highOvercurrentFault,
  output logic            watchdogActive,
  output logic            failsafeMode
);

  // ---------------- link domain (sclk) ----------------
  logic [2:0] bitCntQ;
  logic       xferTglQ;

  // frame ends by csN, so a stopped sclk never leaves a count behind
  always_ff @(posedge sclk or posedge csN or negedge reset_n) begin
    if (!reset_n) begin
      bitCntQ <= 3'h0;
    end else if (csN) begin
      bitCntQ <= 3'h0;
    end else begin
      bitCntQ <= bitCntQ + 3'h1;
    end
  end

  // one toggle per eight-bit command
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      xferTglQ <= 1'b0;
    end else if (!csN && bitCntQ == pwt_pkg::LAST_BIT) begin
      xferTglQ <= ~xferTglQ;
    end
  end

  // ---------------- synchronisers into mclk ----------------
  logic [pwt_pkg::SYNC_N-1:0] asyncIn;
  logic [pwt_pkg::SYNC_N-1:0] metaQ;
  logic [pwt_pkg::SYNC_N-1:0] syncQ;

  assign asyncIn = {xferTglQ, failsafeResistorOn, failsafeResistorGnd,
                    highOvercurrentDet, lowOvercurrentDet, wake};

  genvar gi;
  generate
    for (gi = 0; gi < pwt_pkg::SYNC_N; gi++) begin : gSync
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          metaQ[gi] <= 1'b0;
          syncQ[gi] <= 1'b0;
        end else begin
          metaQ[gi] <= asyncIn[gi];
          syncQ[gi] <= metaQ[gi];
        end
      end
    end
  endgenerate

  logic wakeS;
  logic lowOcS;
  logic highOcS;
  logic fsiGndS;
  logic fsiOnS;
  logic xferTglS;

  assign wakeS    = syncQ[0];
  assign lowOcS   = syncQ[1];
  assign highOcS  = syncQ[2];
  assign fsiGndS  = syncQ[3];
  assign fsiOnS   = syncQ[4];
  assign xferTglS = syncQ[5];

  // ---------------- edge and change detection ----------------
  logic       xferSeenQ;
  logic       startQ;
  logic       hsOnPrevQ;
  logic       wdEnPrevQ;
  logic [1:0] lowSelQ;
  logic [2:0] osdSelQ;
  logic [1:0] wdSelQ;
  logic       xferDone;
  logic       wdEnable;

  assign xferDone = xferTglS ^ xferSeenQ;
  // (RULE6) wake gates watchdog
  // (RULE12) grounded resistor disables
  assign wdEnable = wakeS && !fsiGndS;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xferSeenQ <= 1'b0;
      startQ    <= 1'b1;
      hsOnPrevQ <= 1'b0;
      wdEnPrevQ <= 1'b0;
      lowSelQ   <= 2'h0;
      osdSelQ   <= 3'h0;
      wdSelQ    <= 2'h0;
    end else begin
      xferSeenQ <= xferTglS;
      startQ    <= 1'b0;
      hsOnPrevQ <= hsOn;
      wdEnPrevQ <= wdEnable;
      lowSelQ   <= lowOvercurrentBlankSel;
      osdSelQ   <= outputSwitchDelaySel;
      wdSelQ    <= watchdogPeriodSel;
    end
  end

  // ---------------- timers ----------------
  pwt_timer_if lowIf ();
  pwt_timer_if highIf ();
  pwt_timer_if osdIf ();
  pwt_timer_if wdIf ();

  pwt_interval_timer uLowBlank (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tmr     (lowIf.timer)
  );
  pwt_interval_timer uHighBlank (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tmr     (highIf.timer)
  );
  pwt_interval_timer uSwitchDelay (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tmr     (osdIf.timer)
  );
  pwt_interval_timer uWatchdog (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tmr     (wdIf.timer)
  );

  // (RULE1) low window by code
  // (RULE15) reload on code change
  assign lowIf.load = !lowOcS || !hsOn
                      || (lowOvercurrentBlankSel != lowSelQ);
  assign lowIf.loadValue = LOW_BLANK_CYC[lowOvercurrentBlankSel];
  assign lowIf.run       = lowOcS && hsOn;

  // (RULE2) fixed window from turn-on
  assign highIf.load      = hsOn && !hsOnPrevQ;
  assign highIf.loadValue = pwt_pkg::HIGH_BLANK_CYC;
  assign highIf.run       = hsOn;

  logic targetQ;
  logic cmdQ;

  // (RULE4) delay scales with code
  // (RULE15) reload on code change
  assign osdIf.load = (outputReq != targetQ)
                      || (outputSwitchDelaySel != osdSelQ);
  assign osdIf.loadValue = SWITCH_STEP_CYC
                           * {25'h0000000, outputSwitchDelaySel};
  assign osdIf.run       = 1'b1;

  // (RULE11) first load at reset release
  // (RULE14) transfer restarts count
  // (RULE15) reload on code change
  assign wdIf.load = startQ || xferDone || (wdEnable && !wdEnPrevQ)
                     || (watchdogPeriodSel != wdSelQ);
  assign wdIf.loadValue = WD_CYC[watchdogPeriodSel];
  // (RULE6) count only while enabled
  assign wdIf.run       = wdEnable && !failsafeMode;

  // ---------------- switching delay ----------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      targetQ <= 1'b0;
      cmdQ    <= 1'b0;
    end else begin
      targetQ <= outputReq;
      // (RULE4) output follows after delay
      if (osdIf.done && !osdIf.load) begin
        cmdQ <= targetQ;
      end
    end
  end

  // ---------------- faults ----------------
  logic faultClr;
  // dropping the request is the only way out short of reset
  assign faultClr = !outputReq;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowOvercurrentFault <= 1'b0;
    end else if (lowIf.done && lowIf.run) begin
      // (RULE1) low level after blanking
      lowOvercurrentFault <= 1'b1;
    end else if (faultClr) begin
      lowOvercurrentFault <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      highOvercurrentFault <= 1'b0;
    end else if (highOcS && hsOn && highIf.done && !highIf.load) begin
      // (RULE3) tolerated until window ends
      highOvercurrentFault <= 1'b1;
    end else if (faultClr) begin
      highOvercurrentFault <= 1'b0;
    end
  end

  // ---------------- watchdog and fail-safe ----------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      failsafeMode <= 1'b0;
    end else if (wdIf.done && wdEnable && !wdIf.load) begin
      // (RULE13) timeout leaves normal mode
      failsafeMode <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdogActive <= 1'b0;
    end else begin
      watchdogActive <= wdEnable && !failsafeMode;
    end
  end

  // ---------------- output ----------------
  // (RULE11) output off while reset low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hsOn <= 1'b0;
    end else if (lowOvercurrentFault || highOvercurrentFault) begin
      hsOn <= 1'b0;
    end else if (failsafeMode) begin
      // (RULE12) resistor value picks state
      hsOn <= fsiOnS;
    end else begin
      hsOn <= cmdQ;
    end
  end

endmodule // pwt_protection_timer

// *** dv/pwt_timer_sva.sv ***
// Purpose: port checks of the timer block
// Assumes: one mclk domain
// Notes: age counters kept raw, no sync
`timescale 1ns/100ps
module pwt_timer_sva #(
  parameter logic [3:0][pwt_pkg::CNT_W-1:0] LOW_BLANK_CYC = '0,
  parameter logic [pwt_pkg::CNT_W-1:0] SWITCH_STEP_CYC = '0
) (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       wake,
  input wire logic       failsafeResistorGnd,
  input wire logic       failsafeResistorOn,
  input wire logic       lowOvercurrentDet,
  input wire logic [1:0] lowOvercurrentBlankSel,
  input wire logic [2:0] outputSwitchDelaySel,
  input wire logic       outputReq,
  input wire logic       hsOn,
  input wire logic       lowOvercurrentFault,
  input wire logic       highOvercurrentFault,
  input wire logic       watchdogActive,
  input wire logic       failsafeMode
);
  logic [pwt_pkg::CNT_W-1:0] hsAge_q;
  logic [pwt_pkg::CNT_W-1:0] detAge_q;
  logic [pwt_pkg::CNT_W-1:0] reqAge_q;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) hsAge_q <= '0;
    else hsAge_q <= hsOn ? hsAge_q + 1'b1 : '0;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) detAge_q <= '0;
    else detAge_q <= (lowOvercurrentDet && hsOn) ? detAge_q + 1'b1 : '0;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) reqAge_q <= '0;
    else reqAge_q <= outputReq ? reqAge_q + 1'b1 : '0;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  chk_reset_outputs_off: assert property (
    $rose(reset_n) |-> !hsOn && !failsafeMode && !lowOvercurrentFault)
    else $error("outputs not clear after reset");
  chk_wake_gates_dog: assert property (
    !wake [*4] |-> !watchdogActive) else $error("watchdog on, wake low");
  chk_ground_no_failsafe: assert property (
    failsafeResistorGnd [*5] |-> !$rose(failsafeMode))
    else $error("fail-safe with resistor grounded");
  chk_failsafe_off_out: assert property (
    (failsafeMode && !failsafeResistorOn) [*5] |-> !hsOn)
    else $error("output on in fail-safe off");
  chk_failsafe_sticky: assert property (
    failsafeMode |=> failsafeMode) else $error("fail-safe dropped");
  chk_high_blank_age: assert property (
    $rose(highOvercurrentFault) |-> hsAge_q >= 990)
    else $error("high fault inside blanking");
  chk_low_blank_age: assert property (
    $rose(lowOvercurrentFault) |->
      detAge_q >= LOW_BLANK_CYC[lowOvercurrentBlankSel])
    else $error("low fault inside blanking");
  chk_switch_delay_min: assert property (
    $rose(hsOn) && !failsafeMode |->
      reqAge_q >= SWITCH_STEP_CYC * outputSwitchDelaySel)
    else $error("output switched early");
endmodule // pwt_timer_sva

// *** dv/pwt_host_model.sv ***
// Purpose: host master of the serial link
// Assumes: sclk idles low, csN idles high
// Notes: bench starts frames through frame()
`timescale 1ns/100ps
module pwt_host_model (
  input  wire logic reset_n,
  output logic      sclk,
  output logic      csN
);
  time relT = 0;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
  end
  always @(posedge reset_n) relT = $time;
  // n below 8 leaves a command incomplete
  task automatic frame(input int n);
    if ($time < relT + 5000) #(relT + 5000 - $time);
    csN = 1'b0;
    #200;
    repeat (n) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #200 csN = 1'b1;
    #320;
  endtask
endmodule // pwt_host_model

// *** dv/protection_timer_watchdog_test.sv ***
// Purpose: self-checking bench of the timer block
// Assumes: counts shortened by parameters
// Notes: outs = {failsafe, dogActive, highF, lowF, hsOn}
`timescale 1ns/100ps
module protection_timer_watchdog_test;
  localparam logic [3:0][27:0] LB = {28'ha, 28'h14, 28'h1e, 28'h28};
  localparam logic [3:0][27:0] WD = {28'hc8, 28'h190, 28'h2bc, 28'h3e8};
  localparam logic [27:0]      STEP = 28'h32;
  logic            mclk, reset_n, wake, gnd, fsOn, lowDet, highDet, req;
  logic [1:0]      lSel, wSel;
  logic [2:0]      dSel;
  logic            sclk, csN;
  wire logic [4:0] outs;
  int              nMismatch, cmpCount, ticks;
  pwt_host_model host_u (.reset_n, .sclk, .csN);
  pwt_protection_timer #(.LOW_BLANK_CYC(LB), .SWITCH_STEP_CYC(STEP),
    .WD_CYC(WD)) dut_u (.mclk, .reset_n, .sclk, .csN, .wake,
    .failsafeResistorGnd(gnd), .failsafeResistorOn(fsOn),
    .lowOvercurrentDet(lowDet), .highOvercurrentDet(highDet),
    .lowOvercurrentBlankSel(lSel), .outputSwitchDelaySel(dSel),
    .watchdogPeriodSel(wSel), .outputReq(req), .hsOn(outs[0]),
    .lowOvercurrentFault(outs[1]), .highOvercurrentFault(outs[2]),
    .watchdogActive(outs[3]), .failsafeMode(outs[4]));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // output b reaches v, not before lo cycles, by hi
  task automatic reach(input int b, input logic v, input int lo, hi);
    int k;
    cyc(lo);
    @(negedge mclk);
    if (lo > 0) check(28'(outs[b]), 28'(!v));
    for (k = lo; k < hi && outs[b] !== v; k++) @(negedge mclk);
    check(28'(outs[b]), 28'(v));
    @(posedge mclk);
  endtask
  task automatic rst();
    reset_n <= 1'b0;
    cyc(20);
    reset_n <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 15000) begin
      nMismatch++;
      report_and_stop();
    end
  end
  task automatic test_switch();
    for (int c = 0; c < 8; c++) begin
      dSel <= 3'(c);
      req <= 1'b1;
      reach(0, 1'b1, c * int'(STEP), c * int'(STEP) + 8);
      req <= 1'b0;
      reach(0, 1'b0, c * int'(STEP), c * int'(STEP) + 8);
    end
    $display("switch delay test done");
  endtask
  task automatic test_blank();
    dSel <= 3'h0;
    for (int c = 0; c < 4; c++) begin
      lSel <= 2'(c);
      req <= 1'b1;
      cyc(10);
      lowDet <= 1'b1;
      reach(1, 1'b1, int'(LB[c]), int'(LB[c]) + 8);
      reach(0, 1'b0, 0, 3);
      lowDet <= 1'b0;
      req <= 1'b0;
      reach(1, 1'b0, 0, 4);
    end
    req <= 1'b1;
    highDet <= 1'b1;
    reach(2, 1'b1, 990, 1012);
    reach(0, 1'b0, 0, 3);
    highDet <= 1'b0;
    req <= 1'b0;
    $display("blanking test done");
  endtask
  task automatic test_dog();
    wake <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wSel <= 2'(c);
      rst();
      reach(4, 1'b1, int'(WD[c]) - 2, int'(WD[c]) + 12);
    end
    wSel <= 2'h1;
    rst();
    repeat (5) host_u.frame(8);
    @(negedge mclk);
    check(28'(outs[4:3]), 28'h1);
    reach(4, 1'b1, int'(WD[1]) - 80, int'(WD[1]) + 12);
    fsOn <= 1'b1;
    reach(0, 1'b1, 0, 8);
    fsOn <= 1'b0;
    reach(0, 1'b0, 0, 8);
    wake <= 1'b0;
    wSel <= 2'h3;
    rst();
    cyc(300);
    check(28'(outs[4:3]), 28'h0);
    gnd <= 1'b1;
    wake <= 1'b1;
    cyc(300);
    check(28'(outs[4:3]), 28'h0);
    gnd <= 1'b0;
    reach(4, 1'b1, int'(WD[3]) - 2, int'(WD[3]) + 12);
    $display("watchdog test done");
  endtask
  initial begin
    {reset_n, wake, gnd, fsOn, lowDet, highDet, req} = '0;
    {lSel, wSel, dSel} = '0;
    {nMismatch, cmpCount, ticks} = '0;
    cyc(6);
    reset_n <= 1'b1;
    test_switch();
    test_blank();
    test_dog();
    report_and_stop();
  end
endmodule // protection_timer_watchdog_test
bind pwt_protection_timer pwt_timer_sva #(.LOW_BLANK_CYC(LOW_BLANK_CYC),
  .SWITCH_STEP_CYC(SWITCH_STEP_CYC)) chk_u (.mclk, .reset_n, .wake,
  .failsafeResistorGnd, .failsafeResistorOn, .lowOvercurrentDet,
  .lowOvercurrentBlankSel, .outputSwitchDelaySel, .outputReq, .hsOn,
  .lowOvercurrentFault, .highOvercurrentFault, .watchdogActive,
  .failsafeMode);
